//--- cpu_interrupt_controller.sv
// interrupt controller for an 8-bit core: latching, priority, entry, return, wake-up
// assumes the core holds pc/x/a/cc inputs steady while busy is high
//
// Contract
// (R1) maskable requests serviced only with mask clear; masked ones stay latched
// (R2) entry waits for the current instruction to complete
// (R3) entry pushes pc, x, a and cc; y is not saved
// (R4) entry sets the global mask bit
// (R5) pc loaded from the serviced source's two-byte vector
// (R6) return pops the frame; mask comes back clear, program resumes; the code restores the mask from the stacked cc
// (R7) fixed priority: trap, flash, usb suspend end, external, timer, i2c, serial, usb
// (R8) trap always enters, ignoring the mask, with the same sequence
// (R9) any source wakes from wait; only external or suspend end leave halt
// (R10) lines 1,2,5,6 rise, lines 3,4,7,8 fall; no other pins request
// (R11) external line requests only with its enable set and mask clear
// (R12) peripheral flag interrupts only when enabled and unmasked, else stays pending
// (R13) software clears a peripheral flag by writing zero or access sequence
// (R14) the clearing sequence discards the internal request latch
// (R15) vector pairs FFFEh down to FFEEh per source
// (R16) external enable byte at 0008h, resets to 00h, bit i enables line i+1
// (R17) software disables analog input on port b pins before using them
`timescale 1ns/1ps
module cpu_interrupt_controller (
	input  logic                         clk_sys,        // 50 MHz system clock
	input  logic                         rst,            // synchronous reset, active high
	input  logic [7:0]                   reg_addr,       // register address
	input  logic [7:0]                   reg_wdata,      // register write data
	input  logic                         reg_wr,         // write strobe
	input  logic                         reg_rd,         // read strobe
	output logic [7:0]                   reg_rdata,      // read data, cycle after reg_rd
	input  logic [intc_pkg::NUM_EXT-1:0] ext_pin,        // external request lines 8..1
	input  logic [intc_pkg::NUM_PER-1:0] periph_flag,    // peripheral status flags
	input  logic [intc_pkg::NUM_PER-1:0] periph_enable,  // peripheral control enables
	input  logic [intc_pkg::NUM_PER-1:0] periph_clear,   // clearing sequence done
	input  logic                         insn_done,      // instruction boundary pulse
	input  logic                         trap_exec,      // trap instruction executing
	input  logic                         return_from_service_exec,      // return_from_service executing
	input  logic                         wfi_exec,       // enter wait mode
	input  logic                         halt_exec,      // enter halt mode
	input  logic                         mask_set,       // software sets mask
	input  logic                         mask_clr,       // software clears mask
	input  logic [15:0]                  pc_in,          // core program counter
	input  logic [7:0]                   x_in,           // first index register
	input  logic [7:0]                   a_in,           // accumulator
	input  logic [7:0]                   cc_in,          // condition_code_register
	output logic                         mask_bit,       // global mask bit
	output logic                         busy,           // entry or return in progress
	output logic                         cpu_stopped,    // core stopped in wait or halt
	output logic                         vector_load,    // fetch pc from vector_addr
	output logic [15:0]                  vector_addr,    // vector low byte address
	output logic                         restore_load,   // load restored context
	output logic [15:0]                  restore_pc,     // popped program counter
	output logic [7:0]                   restore_x,      // popped index register
	output logic [7:0]                   restore_a,      // popped accumulator
	output logic [7:0]                   restore_cc,     // popped condition codes
	output logic                         irq_out         // event interrupt, level
);

	intc_pkg::state_type             state_q;
	logic [2:0]                      step_q;
	logic [2:0]                      sel_q;
	logic [2:0]                      sel_d;
	logic                            busy_q;
	logic                            stopped_q;
	logic                            mask_q;
	logic [intc_pkg::SP_W-1:0]       sp_q;
	logic [7:0]                      ext_enable_q;
	logic [intc_pkg::NUM_EXT-1:0]    ext_prev_q;
	logic                            ext_seen_q;
	logic [intc_pkg::NUM_EXT-1:0]    ext_edge;
	logic [intc_pkg::NUM_EXT-1:0]    ext_pend_q;
	logic [intc_pkg::NUM_PER-1:0]    periph_pend_q;
	logic [intc_pkg::NUM_PER-1:0]    per_armed;
	logic                            trap_pend_q;
	logic                            ext_armed;
	logic [intc_pkg::NUM_SRC-1:0]    src_armed;
	logic [intc_pkg::NUM_SRC-1:0]    src_req;
	logic                            any_req;
	logic                            accept;
	logic                            enter_low;
	logic [7:0]                      cc_push;
	logic [intc_pkg::EVT_W-1:0]      evt_set;
	logic [intc_pkg::EVT_W-1:0]      evt_clr;
	logic [intc_pkg::EVT_W-1:0]      status_q;
	logic [intc_pkg::EVT_W-1:0]      evmask_q;
	logic                            irq_q;
	logic [7:0]                      rdata_q;
	logic                            vector_load_q;
	logic [15:0]                     vector_addr_q;
	logic                            restore_load_q;
	logic [15:0]                     restore_pc_q;
	logic [7:0]                      restore_x_q;
	logic [7:0]                      restore_a_q;
	logic [7:0]                      restore_cc_q;

	stack_if stk ();

	stack_ram u_stack (
		.clk_sys (clk_sys),
		.rst     (rst),
		.port    (stk.mem)
	);

	// external enable byte
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_enable_q <= intc_pkg::EXT_ENABLE_RESET;  // [R16]
		end else if (reg_wr && reg_addr == intc_pkg::REG_EXT_ENABLE) begin
			ext_enable_q <= reg_wdata;  // [R16]
		end
	end

	// pin history; the first sample after reset arms edge detection so that
	// a pin already high or low at reset does not look like an edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_prev_q <= '0;
			ext_seen_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_pin;
			ext_seen_q <= 1'b1;
		end
	end

	// per-line edge polarity
	for (genvar i = 0; i < intc_pkg::NUM_EXT; i++) begin : g_edge
		assign ext_edge[i] = ext_seen_q && (intc_pkg::EXT_RISING[i] ?
			(ext_pin[i] && !ext_prev_q[i]) : (!ext_pin[i] && ext_prev_q[i]));  // [R10]
	end

	// external latches: only enabled lines latch; taking the shared vector
	// clears them, but a new edge in that cycle wins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ext_pend_q <= '0;
		end else begin
			for (int i = 0; i < intc_pkg::NUM_EXT; i++) begin
				if (ext_edge[i] && ext_enable_q[i]) begin
					ext_pend_q[i] <= 1'b1;  // [R11]
				end else if (accept && sel_d == intc_pkg::SRC_EXT) begin
					ext_pend_q[i] <= 1'b0;
				end
			end
		end
	end

	// peripheral latches hold while disabled or masked; the clearing sequence drops them only once the flag is low, a set flag wins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			periph_pend_q <= '0;
		end else begin
			for (int i = 0; i < intc_pkg::NUM_PER; i++) begin
				if (periph_flag[i]) begin
					periph_pend_q[i] <= 1'b1;  // [R12]
				end else if (periph_clear[i]) begin
					periph_pend_q[i] <= 1'b0;  // [R14]
				end
			end
		end
	end

	// trap request from the core, kept until its entry starts
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			trap_pend_q <= 1'b0;
		end else if (trap_exec) begin
			trap_pend_q <= 1'b1;
		end else if (accept && sel_d == intc_pkg::SRC_TRAP) begin
			trap_pend_q <= 1'b0;
		end
	end

	// source vector in priority order; the trap ignores the mask
	assign ext_armed = |(ext_pend_q & ext_enable_q);  // [R11]
	assign per_armed = periph_pend_q & periph_enable;  // [R12]
	assign src_armed = {per_armed[5], per_armed[4], per_armed[3], per_armed[2],
		ext_armed, per_armed[1], per_armed[0], trap_pend_q};
	assign src_req = src_armed & (intc_pkg::TRAP_SRC_BIT | {intc_pkg::NUM_SRC{!mask_q}});  // [R1] [R8]
	assign any_req = |src_req;

	// lowest index wins
	always_comb begin
		sel_d = intc_pkg::SRC_TRAP;
		for (int i = intc_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (src_req[i]) begin
				sel_d = 3'(i);  // [R7]
			end
		end
	end

	// start entry only at an instruction boundary, or on wake-up
	assign accept = (state_q == intc_pkg::st_idle && insn_done && any_req)  // [R2]
		|| (state_q == intc_pkg::st_wait && any_req)  // [R9]
		|| (state_q == intc_pkg::st_halt && |(src_req & intc_pkg::HALT_WAKE_SRC));  // [R9]
	assign enter_low = state_q == intc_pkg::st_idle && !accept && (wfi_exec || halt_exec);

	// sequencer
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q   <= intc_pkg::st_idle;
			step_q    <= '0;
			sel_q     <= intc_pkg::SRC_TRAP;
			busy_q    <= 1'b0;
			stopped_q <= 1'b0;
		end else begin
			unique case (state_q)
				intc_pkg::st_idle, intc_pkg::st_wait, intc_pkg::st_halt: begin
					if (accept) begin
						state_q   <= intc_pkg::st_push;
						step_q    <= '0;
						sel_q     <= sel_d;
						busy_q    <= 1'b1;
						stopped_q <= 1'b0;
					end else if (state_q == intc_pkg::st_idle && wfi_exec) begin
						state_q   <= intc_pkg::st_wait;
						stopped_q <= 1'b1;
					end else if (state_q == intc_pkg::st_idle && halt_exec) begin
						state_q   <= intc_pkg::st_halt;
						stopped_q <= 1'b1;
					end else if (state_q == intc_pkg::st_idle && return_from_service_exec) begin
						state_q <= intc_pkg::st_pop;
						step_q  <= '0;
						busy_q  <= 1'b1;
					end
				end
				intc_pkg::st_push: begin
					if (step_q == intc_pkg::SLOT_CC) begin
						state_q <= intc_pkg::st_vector;
					end else begin
						step_q <= step_q + intc_pkg::STEP_ONE;
					end
				end
				intc_pkg::st_vector: begin
					state_q <= intc_pkg::st_idle;
					busy_q  <= 1'b0;
				end
				intc_pkg::st_pop: begin
					if (step_q == intc_pkg::POP_LAST) begin
						state_q <= intc_pkg::st_idle;
						busy_q  <= 1'b0;
					end else begin
						step_q <= step_q + intc_pkg::STEP_ONE;
					end
				end
			endcase
		end
	end

	// stack port: push writes then decrements, pop increments then reads
	assign stk.we   = state_q == intc_pkg::st_push;  // [R3]
	assign stk.re   = state_q == intc_pkg::st_pop && step_q != intc_pkg::POP_LAST;  // [R6]
	assign stk.addr = stk.we ? sp_q : sp_q + intc_pkg::SP_STEP;

	// frame byte for this step; y is never part of the frame
	always_comb begin
		cc_push = cc_in;
		cc_push[intc_pkg::CC_I_BIT] = mask_q;
		unique case (step_q)
			intc_pkg::SLOT_PCL: stk.wdata = pc_in[7:0];  // [R3]
			intc_pkg::SLOT_PCH: stk.wdata = pc_in[15:8];
			intc_pkg::SLOT_X:   stk.wdata = x_in;
			intc_pkg::SLOT_A:   stk.wdata = a_in;
			default:            stk.wdata = cc_push;
		endcase
	end

	// stack pointer wraps silently inside its 128 bytes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp_q <= intc_pkg::SP_RESET;
		end else if (stk.we) begin
			sp_q <= sp_q - intc_pkg::SP_STEP;
		end else if (stk.re) begin
			sp_q <= sp_q + intc_pkg::SP_STEP;
		end
	end

	// popped bytes arrive one step after their read, cc first, pcl last
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			restore_load_q <= 1'b0;
			restore_pc_q   <= '0;
			restore_x_q    <= '0;
			restore_a_q    <= '0;
			restore_cc_q   <= '0;
		end else begin
			restore_load_q <= state_q == intc_pkg::st_pop && step_q == intc_pkg::POP_LAST;  // [R6]
			if (state_q == intc_pkg::st_pop && step_q != '0) begin
				unique case (3'(intc_pkg::POP_LAST - step_q))
					intc_pkg::SLOT_CC:  restore_cc_q        <= stk.rdata;
					intc_pkg::SLOT_A:   restore_a_q         <= stk.rdata;
					intc_pkg::SLOT_X:   restore_x_q         <= stk.rdata;
					intc_pkg::SLOT_PCH: restore_pc_q[15:8]  <= stk.rdata;
					default:            restore_pc_q[7:0]   <= stk.rdata;
				endcase
			end
		end
	end

	// vector hand-off after the frame is on the stack
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			vector_load_q <= 1'b0;
			vector_addr_q <= intc_pkg::VEC_RESET;
		end else begin
			vector_load_q <= state_q == intc_pkg::st_vector;  // [R5]
			if (state_q == intc_pkg::st_vector) begin
				vector_addr_q <= intc_pkg::VECTOR_TABLE[sel_q];  // [R5] [R15]
			end
		end
	end

	// global mask: hardware actions take precedence over the core's own set/clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mask_q <= intc_pkg::MASK_RESET;
		end else if (state_q == intc_pkg::st_push && step_q == intc_pkg::SLOT_CC) begin
			mask_q <= 1'b1;  // [R4]
		end else if (state_q == intc_pkg::st_pop && step_q == intc_pkg::POP_LAST) begin
			mask_q <= restore_cc_q[intc_pkg::CC_I_BIT];  // [R6]
		end else if (enter_low || mask_clr) begin
			mask_q <= 1'b0;
		end else if (mask_set) begin
			mask_q <= 1'b1;
		end
	end

	// event sources for the status register
	always_comb begin
		evt_set = '0;
		evt_set[intc_pkg::EVT_ENTRY]  = state_q == intc_pkg::st_vector;
		evt_set[intc_pkg::EVT_RETURN] = state_q == intc_pkg::st_pop && step_q == intc_pkg::POP_LAST;
		evt_set[intc_pkg::EVT_WAKE]   = accept && state_q != intc_pkg::st_idle;
		evt_set[intc_pkg::EVT_TRAP]   = accept && sel_d == intc_pkg::SRC_TRAP;
		evt_clr = '0;
		if (reg_wr && reg_addr == intc_pkg::REG_EVT_STATUS) begin
			evt_clr = reg_wdata[intc_pkg::EVT_W-1:0];
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			status_q <= intc_pkg::EVT_RESET;
			evmask_q <= intc_pkg::EVT_RESET;
			irq_q    <= 1'b0;
		end else begin
			status_q <= (status_q & ~evt_clr) | evt_set;
			if (reg_wr && reg_addr == intc_pkg::REG_EVT_MASK) begin
				evmask_q <= reg_wdata[intc_pkg::EVT_W-1:0];
			end
			irq_q <= |(status_q & evmask_q);
		end
	end

	// read data live for one cycle only; unmapped addresses read zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= '0;
			if (reg_rd) begin
				unique case (reg_addr)
					intc_pkg::REG_EXT_ENABLE:  rdata_q <= ext_enable_q;  // [R16]
					intc_pkg::REG_EVT_STATUS:  rdata_q <= 8'(status_q);
					intc_pkg::REG_EVT_MASK:    rdata_q <= 8'(evmask_q);
					intc_pkg::REG_EXT_PENDING: rdata_q <= ext_pend_q;
					default:                   rdata_q <= '0;
				endcase
			end
		end
	end

	assign reg_rdata    = rdata_q;
	assign mask_bit     = mask_q;
	assign busy         = busy_q;
	assign cpu_stopped  = stopped_q;
	assign vector_load  = vector_load_q;
	assign vector_addr  = vector_addr_q;
	assign restore_load = restore_load_q;
	assign restore_pc   = restore_pc_q;
	assign restore_x    = restore_x_q;
	assign restore_a    = restore_a_q;
	assign restore_cc   = restore_cc_q;
	assign irq_out      = irq_q;

	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_mask_blocks: assert property (accept && sel_d != intc_pkg::SRC_TRAP |-> !mask_q)  // [R1]
		else $error("maskable request taken while masked");
	a_entry_boundary: assert property (  // [R2]
		state_q == intc_pkg::st_idle && !insn_done |=> state_q != intc_pkg::st_push)
		else $error("entry started inside an instruction");
	a_push_frame: assert property (accept |=> stk.we [*5] ##1 !stk.we)  // [R3]
		else $error("entry frame is not five bytes");
	a_mask_on_entry: assert property (accept |-> ##6 mask_q)  // [R4]
		else $error("mask not set after entry");
	a_vector_load: assert property (accept |-> ##7 (vector_load_q  // [R5]
		&& vector_addr_q == intc_pkg::VECTOR_TABLE[$past(sel_d, 7)]))
		else $error("wrong vector or vector timing");
	a_return_restore: assert property (  // [R6]
		restore_load_q |-> mask_q == restore_cc_q[intc_pkg::CC_I_BIT] && !busy_q)
		else $error("mask not restored on return");
	a_ext_priority: assert property (accept && src_req[intc_pkg::SRC_EXT]  // [R7]
		&& !(|src_req[intc_pkg::SRC_USB_SUSP:intc_pkg::SRC_TRAP]) |=> sel_q == intc_pkg::SRC_EXT)
		else $error("external request lost its priority");
	a_trap_unmasked: assert property (  // [R8]
		state_q == intc_pkg::st_idle && insn_done && trap_pend_q
		|=> state_q == intc_pkg::st_push && sel_q == intc_pkg::SRC_TRAP)
		else $error("trap not entered");
	a_halt_hold: assert property (state_q == intc_pkg::st_halt  // [R9]
		&& !(|(src_armed & intc_pkg::HALT_WAKE_SRC)) |=> state_q == intc_pkg::st_halt)
		else $error("halt left without a wake source");
	a_wait_wake: assert property (  // [R9]
		state_q == intc_pkg::st_wait && |src_armed |=> state_q == intc_pkg::st_push)
		else $error("wait not left on a request");
	a_edge_gate: assert property (  // [R10] [R11]
		(ext_pend_q & ~$past(ext_pend_q) & ~$past(ext_edge & ext_enable_q)) == '0)
		else $error("external latch set without an enabled edge");
	a_clear_discards: assert property (|(periph_clear & ~periph_flag)  // [R14]
		|=> (periph_pend_q & $past(periph_clear & ~periph_flag)) == '0)
		else $error("pending request survived its clear");

endmodule : cpu_interrupt_controller

//--- intc_pkg.sv
// constants, register map and state type of the cpu interrupt controller
// assumes one 50 MHz clock and a byte-wide register port with registered read data
package intc_pkg;

	// source slots, index 0 is the highest priority
	localparam int               NUM_SRC      = 8;
	localparam int               NUM_EXT      = 8;
	localparam int               NUM_PER      = 6;
	localparam logic [2:0]       SRC_TRAP     = 3'h0;
	localparam logic [2:0]       SRC_FLASH    = 3'h1;
	localparam logic [2:0]       SRC_USB_SUSP = 3'h2;
	localparam logic [2:0]       SRC_EXT      = 3'h3;
	localparam logic [2:0]       SRC_TIMER    = 3'h4;
	localparam logic [2:0]       SRC_I2C      = 3'h5;
	localparam logic [2:0]       SRC_SCI      = 3'h6;
	localparam logic [2:0]       SRC_USB      = 3'h7;

	// low byte address of each two-byte vector; reset is fetched by the core itself
	localparam logic [15:0]      VEC_RESET    = 16'hFFFE;
	localparam logic [15:0]      VECTOR_TABLE [NUM_SRC] = '{
		16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFF0, 16'hFFEE
	};

	// lines 1,2,5,6 fire on a rising edge, the others on a falling edge
	localparam logic [NUM_EXT-1:0] EXT_RISING    = 8'h33;
	localparam logic [NUM_SRC-1:0] HALT_WAKE_SRC = 8'h0C;
	localparam logic [NUM_SRC-1:0] TRAP_SRC_BIT  = 8'h01;

	// register port
	localparam logic [7:0]       REG_EXT_ENABLE   = 8'h08;
	localparam logic [7:0]       REG_EVT_STATUS   = 8'h09;
	localparam logic [7:0]       REG_EVT_MASK     = 8'h0A;
	localparam logic [7:0]       REG_EXT_PENDING  = 8'h0B;
	localparam logic [7:0]       EXT_ENABLE_RESET = 8'h00;

	// stack: 128 bytes, pointer low part, full pointer resets to 017Fh
	localparam int               SP_W     = 7;
	localparam logic [SP_W-1:0]  SP_RESET = 7'h7F;
	localparam logic [SP_W-1:0]  SP_STEP  = 7'h01;

	// frame slots in push order; pop walks them backwards
	localparam logic [2:0]       SLOT_PCL = 3'h0;
	localparam logic [2:0]       SLOT_PCH = 3'h1;
	localparam logic [2:0]       SLOT_X   = 3'h2;
	localparam logic [2:0]       SLOT_A   = 3'h3;
	localparam logic [2:0]       SLOT_CC  = 3'h4;
	localparam logic [2:0]       POP_LAST = 3'h5;
	localparam logic [2:0]       STEP_ONE = 3'h1;
	localparam int               CC_I_BIT = 3;
	localparam logic             MASK_RESET = 1'b1;

	// event status bits
	localparam int               EVT_W      = 4;
	localparam int               EVT_ENTRY  = 0;
	localparam int               EVT_RETURN = 1;
	localparam int               EVT_WAKE   = 2;
	localparam int               EVT_TRAP   = 3;
	localparam logic [EVT_W-1:0] EVT_RESET  = 4'h0;

	typedef enum logic [2:0] {
		st_idle,
		st_push,
		st_vector,
		st_pop,
		st_wait,
		st_halt
	} state_type;

endpackage : intc_pkg

//--- stack_if.sv
// port bundle between the interrupt sequencer and its stack memory
// assumes both ends share clk_sys; read data arrive one cycle after re
`timescale 1ns/1ps
interface stack_if;
	logic                      we;     // write byte at addr
	logic                      re;     // read byte at addr
	logic [intc_pkg::SP_W-1:0] addr;   // stack byte address
	logic [7:0]                wdata;  // byte to write
	logic [7:0]                rdata;  // registered read byte

	modport ctrl (output we, output re, output addr, output wdata, input rdata);
	modport mem (input we, input re, input addr, input wdata, output rdata);
endinterface : stack_if

//--- stack_ram.sv
// 128-byte stack memory used for interrupt context frames
// assumes a single clock; read data come out of a register one cycle after re
`timescale 1ns/1ps
module stack_ram (
	input  logic clk_sys,        // system clock
	input  logic rst,            // synchronous reset, clears read data only
	stack_if.mem port            // access from the sequencer
);

	logic [7:0] mem_q [2**intc_pkg::SP_W];
	logic [7:0] rdata_q;

	// array content is not reset: a frame is always written before it is read
	always_ff @(posedge clk_sys) begin
		if (port.we) begin
			mem_q[port.addr] <= port.wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (port.re) begin
			rdata_q <= mem_q[port.addr];
		end
	end

	assign port.rdata = rdata_q;

endmodule : stack_ram

//--- core_model.sv
// core model: instruction boundaries and a program counter that jumps
// assumes the controller's busy, stop and load outputs on clk_sys
`timescale 1ns/1ps
module core_model (
	input  wire logic        clk_sys, // clock
	input  wire logic        rst,     // reset
	input  wire logic        busy,    // sequence running
	input  wire logic        stopped, // wait or halt
	input  wire logic        vec_ld,  // vector fetch
	input  wire logic        res_ld,  // context restore
	input  wire logic [15:0] res_pc,  // restored pc
	output logic             done,    // boundary pulse
	output logic [15:0]      pc_q     // program counter
);
	logic [1:0] cnt_q;
	// a boundary every fourth cycle, never while stopped or stacking
	always_ff @(posedge clk_sys) begin
		cnt_q <= rst ? 2'h0 : cnt_q + 2'h1;
		done <= !rst && cnt_q == 2'h3 && !busy && !stopped;
	end
	// pc moves only on a jump, so it stands still while being stacked
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc_q <= 16'h1234;
		end else if (vec_ld) begin
			pc_q <= pc_q ^ 16'h5A5A;
		end else if (res_ld) begin
			pc_q <= res_pc;
		end
	end
endmodule : core_model

//--- test_cpu_interrupt_controller.sv
// bench for the interrupt controller with a behavioural core beside it
// assumes core_model and the design files are compiled first
`timescale 1ns/1ps
`define CHK(g,e) begin check_count++; if ((g) !== (e)) begin failures++; \
 $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_cpu_interrupt_controller;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, trap_exec = 0, return_from_service_exec = 0;
	logic wfi_exec = 0, halt_exec = 0, mask_set = 0, mask_clr = 0, rd_q = 0;
	logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d, ext_pin = ~intc_pkg::EXT_RISING;
	logic [5:0] periph_flag = '0, periph_enable = '0, periph_clear = '0;
	logic [15:0] pc_in, vector_addr, restore_pc, vq[$], pq[$];
	logic insn_done, mask_bit, busy, cpu_stopped, vector_load, restore_load, irq_out;
	logic [7:0] rq[$], cq[$], restore_x, restore_a, restore_cc;
	int failures = 0, check_count = 0, vec_n = 0, res_n = 0, cyc = 0, bc = 0;
	cpu_interrupt_controller DUT (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .ext_pin, .periph_flag, .periph_enable, .periph_clear, .insn_done,
		.trap_exec, .return_from_service_exec, .wfi_exec, .halt_exec, .mask_set, .mask_clr, .pc_in,
		.x_in(8'hA5), .a_in(8'h3C), .cc_in(8'hC0), .mask_bit, .busy, .cpu_stopped,
		.vector_load, .vector_addr, .restore_load, .restore_pc, .restore_x, .restore_a,
		.restore_cc, .irq_out);
	core_model core (.clk_sys, .rst, .busy, .stopped(cpu_stopped), .vec_ld(vector_load),
		.res_ld(restore_load), .res_pc(restore_pc), .done(insn_done), .pc_q(pc_in));
	initial forever #10 clk_sys = ~clk_sys;
	task w(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : w
	task wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a; reg_wdata <= v; reg_wr <= 1; w(1); reg_wr <= 0; w(1);
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a; reg_rd <= 1; rq.push_back(e); w(1); reg_rd <= 0; w(1);
	endtask : rd
	// one entry then one return, clearing the serviced peripheral flags between
	task serve(input logic [15:0] v, input logic [5:0] c, input logic m);
		int k;
		vq.push_back(v); pq.push_back(pc_in); k = vec_n;
		cq.push_back({4'hC, m, 3'h0}); // stacked cc carries the mask held before entry
		for (int i = 0; i < 300 && vec_n == k; i++) w(1);
		`CHK(vec_n != k && mask_bit, 1'b1)
		periph_flag <= periph_flag & ~c; periph_clear <= c;
		w(1); periph_clear <= '0; return_from_service_exec <= 1; w(1); return_from_service_exec <= 0; k = res_n;
		for (int i = 0; i < 300 && res_n == k; i++) w(1);
		`CHK(res_n != k && mask_bit === m, 1'b1)
	endtask : serve
	task end_sim;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// watcher: results taken at the falling edge, when they have settled
	always @(negedge clk_sys) begin
		cyc++;
		if (rd_q) `CHK(reg_rdata, rq.pop_front())
		rd_q = reg_rd;
		bc += busy; // busy cycles of the running sequence
		if (vector_load) begin vec_n++; `CHK(vector_addr, vq.pop_front()) end
		if (vector_load) begin `CHK(bc, 6) bc = 0; end
		if (restore_load) begin res_n++; `CHK(restore_pc, pq.pop_front()) end
		if (restore_load) begin
			`CHK({restore_x, restore_a, restore_cc}, {16'hA53C, cq.pop_front()})
			`CHK(bc, 6)
			bc = 0;
		end
		if (cyc == 20000) begin failures++; end_sim(); end
	end
	initial begin
		void'($urandom(32'h0adeb654));
		w(8); rst <= 0; w(2);
		rd(8'h08, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom); wr(8'h08, d); rd(8'h08, d);
		end
		rd(8'h3F, 8'h00);
		// three flags raised together under the mask, then released
		periph_enable <= 6'h34; periph_flag <= 6'h34; w(20);
		`CHK(vec_n, 0)
		mask_clr <= 1; w(1); mask_clr <= 0;
		serve(16'hFFF4, 6'h04, 1'b0);
		serve(16'hFFF0, 6'h10, 1'b0);
		serve(16'hFFEE, 6'h20, 1'b0);
		// event irq only once nothing is pending, so no entry races the clear
		rd(8'h09, 8'h03); wr(8'h0A, 8'h01); w(2);
		`CHK(irq_out, 1'b1)
		wr(8'h09, 8'h0F); w(2);
		`CHK(irq_out, 1'b0)
		// disabled flags wait; a cleared one is lost for good
		periph_enable <= '0; periph_flag <= 6'h03; w(10);
		`CHK(vec_n, 3)
		periph_flag <= 6'h01; periph_clear <= 6'h02; w(1); periph_clear <= '0;
		mask_set <= 1; w(1); mask_set <= 0; periph_enable <= 6'h3F; trap_exec <= 1;
		w(1); trap_exec <= 0;
		serve(16'hFFFC, 6'h00, 1'b1);
		mask_clr <= 1; w(1); mask_clr <= 0;
		serve(16'hFFFA, 6'h01, 1'b0);
		// pins are driven as plain digital levels, their analog function off
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, 8'h01 << i); ext_pin[i] <= ~ext_pin[i];
			serve(16'hFFF6, 6'h00, 1'b0);
			ext_pin[i] <= ~ext_pin[i]; w(4);
		end
		wfi_exec <= 1; w(1); wfi_exec <= 0; w(5);
		`CHK(cpu_stopped, 1'b1)
		periph_flag <= 6'h04; serve(16'hFFF4, 6'h04, 1'b0);
		halt_exec <= 1; w(1); halt_exec <= 0; periph_flag <= 6'h04; w(10);
		`CHK(cpu_stopped, 1'b1)
		ext_pin[7] <= ~ext_pin[7]; serve(16'hFFF6, 6'h00, 1'b0);
		serve(16'hFFF4, 6'h04, 1'b0);
		w(10); end_sim();
	end
endmodule : test_cpu_interrupt_controller
